// [frame_checksum_pkg.sv]
// Shared constants and carrier types for the frame checksum offload block.
package frame_checksum_pkg;

    // ============================================================
    // Register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_VLAN = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_RX_SUM = 8'h0C;
    localparam logic [7:0] ADDR_TX_SUM = 8'h10;

    localparam int CTRL_RX_EN_BIT = 0;
    localparam int CTRL_RX_MODE_BIT = 1;
    localparam int CTRL_TX_EN_BIT = 16;
    localparam int CTRL_TX_MODE_BIT = 17;
    localparam logic [31:0] CTRL_WRITE_MASK = 32'h0003_0003;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] VLAN_RESET = 16'h8100;

    localparam int STATUS_RX_BUSY_BIT = 0;
    localparam int STATUS_TX_BUSY_BIT = 1;

    // ============================================================
    // Frame layout
    localparam int IW = 12;
    localparam logic [IW-1:0] MAC_HDR_BYTES = 12'h00E;
    localparam logic [IW-1:0] FIRST_TYPE_END = 12'h00D;
    localparam logic [IW-1:0] VLAN_TAG_BYTES = 12'h004;
    localparam logic [IW-1:0] SNAP_BYTES = 12'h008;
    localparam logic [1:0] MAX_VLAN_TAGS = 2'h2;
    localparam logic [15:0] LENGTH_TYPE_LIMIT = 16'h0600;

    // ============================================================
    // Transmit command and preamble fields
    localparam int FIRST_SEG_BIT = 12;
    localparam int CSUM_REQ_BIT = 13;
    localparam int PRE_START_LSB = 0;
    localparam int PRE_LOC_LSB = 16;
    localparam int PRE_ZERO_SUB_BIT = 31;
    localparam logic [1:0] PRE_LAST_BYTE = 2'h3;
    localparam logic [15:0] ZERO_SUM = 16'h0000;
    localparam logic [15:0] ZERO_SUBSTITUTE = 16'hFFFF;

    // ============================================================
    // Carriers
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } byte_stream_t;

    typedef struct packed {
        logic valid;
        logic last;
        logic csum_added;
        logic [7:0] data;
    } rx_stream_t;

    typedef struct packed {
        logic valid;
        logic [31:0] cmd_a;
        logic [31:0] cmd_b;
    } tx_cmd_t;

endpackage

// [csum_accum.sv]
// Ones-complement 16-bit accumulator fed one byte at a time.
module csum_accum
    import frame_checksum_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic clear_in,
    input wire logic add_in,
    input wire logic [7:0] data_in,
    output logic [15:0] sum_out
);

    logic [15:0] sum;
    logic [7:0] low;
    logic odd;
    logic [15:0] next_sum;
    logic [7:0] next_low;
    logic next_odd;

    function automatic logic [15:0] ones_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[15:0] + {15'h0000, s[16]};
    endfunction

    always_comb begin
        next_sum = clear_in ? ZERO_SUM : sum;
        next_low = clear_in ? 8'h00 : low;
        next_odd = clear_in ? 1'b0 : odd;
        if (add_in) begin
            if (next_odd) begin
                next_sum = ones_add(next_sum, {data_in, next_low});
                next_odd = 1'b0;
            end else begin
                next_low = data_in;
                next_odd = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sum <= ZERO_SUM;
            low <= 8'h00;
            odd <= 1'b0;
        end else begin
            sum <= next_sum;
            low <= next_low;
            odd <= next_odd;
        end
    end

    // A dangling byte is closed with a zero high byte.
    assign sum_out = odd ? ones_add(sum, {8'h00, low}) : sum;

endmodule

// [rx_l3_locator.sv]
// Finds where summing begins inside a received frame, per byte.
module rx_l3_locator
    import frame_checksum_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic valid_in,
    input wire logic first_in,
    input wire logic [7:0] data_in,
    input wire logic mode_in,
    input wire logic [15:0] vlan_type_in,
    output logic sum_byte_out
);

    logic [IW-1:0] cnt, start, type_end;
    logic [1:0] tags;
    logic known;
    logic [7:0] prev;
    logic [IW-1:0] next_cnt, next_start, next_type_end, idx;
    logic [1:0] next_tags;
    logic next_known;
    logic [15:0] type_field;

    always_comb begin
        idx = first_in ? '0 : cnt;
        next_cnt = cnt;
        next_start = first_in ? MAC_HDR_BYTES : start;
        next_type_end = first_in ? FIRST_TYPE_END : type_end;
        next_tags = first_in ? 2'h0 : tags;
        next_known = first_in ? !mode_in : known;
        type_field = {prev, data_in};
        if (valid_in) begin
            next_cnt = idx + 12'h001;
            if (!next_known && idx == next_type_end) begin
                if (type_field == vlan_type_in && next_tags < MAX_VLAN_TAGS) begin
                    next_tags = next_tags + 2'h1;
                    next_type_end = next_type_end + VLAN_TAG_BYTES;
                end else if (type_field < LENGTH_TYPE_LIMIT) begin
                    next_start = idx + 12'h001 + SNAP_BYTES;
                    next_known = 1'b1;
                end else begin
                    // A third tag identifier lands here and is taken as the type.
                    next_start = idx + 12'h001;
                    next_known = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt <= '0;
            start <= MAC_HDR_BYTES;
            type_end <= FIRST_TYPE_END;
            tags <= 2'h0;
            known <= 1'b0;
            prev <= 8'h00;
        end else begin
            cnt <= next_cnt;
            start <= next_start;
            type_end <= next_type_end;
            tags <= next_tags;
            known <= next_known;
            prev <= valid_in ? data_in : prev;
        end
    end

    // The start is always decided before the byte it points at arrives.
    assign sum_byte_out = valid_in && (first_in ? !mode_in : known) && idx >= (first_in ? MAC_HDR_BYTES : start);

endmodule

// [frame_checksum_offload.sv]
// Receive and transmit checksum offload with an AHB-Lite register slave.
//
// Behaviour
// - When enabled, every received frame gets a checksum.
// - Mode 0 starts summing after byte 14.
// - Mode 1 skips two VLAN tags and SNAP.
// - VLAN tag recognised by programmable type value.
// - Third tag identifier treated as type field.
// - Sum ends before FCS, pads included.
// - Append checksum after frame; length grows two.
// - Enable and mode bits; disabled passes through.
// - Sixteen-bit words, odd byte padded with zero.
// - Word is later byte high; carries wrap back.
// - Transmit sum needs first-segment, request and enable.
// - Transmit sum starts at preamble offset field.
// - Preamble bit 31 turns zero into FFFF.
// - Request flag clear passes packet unmodified.
// - Preamble word dropped on first segment when transmit engine enabled.
// - Inserted value is ones-complement of sum.
module frame_checksum_offload
    import frame_checksum_pkg::*;
#(
    parameter int TX_BUF_DEPTH = 2048
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire byte_stream_t rx_in,
    output logic rx_ready_out,
    output rx_stream_t rx_out,
    input wire tx_cmd_t tx_cmd_in,
    output logic tx_cmd_ready_out,
    input wire byte_stream_t tx_in,
    output logic tx_ready_out,
    output byte_stream_t tx_out
);

    localparam int AW = $clog2(TX_BUF_DEPTH);

    typedef enum logic [1:0] {RX_PASS, RX_SUM_LO, RX_SUM_HI} rx_state_t;
    typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_LOAD, TX_SEND} tx_state_t;

    // ============================================================
    // Register slave
    logic [31:0] ctrl, next_ctrl;
    logic [15:0] vlan_type, next_vlan_type;
    logic [15:0] rx_sum, next_rx_sum;
    logic [15:0] tx_sum, next_tx_sum;
    logic wr_pend, next_wr_pend;
    logic [7:0] wr_addr, next_wr_addr;
    logic [31:0] next_hrdata;
    logic rd_req;
    rx_state_t rx_state, next_rx_state;
    tx_state_t tx_state, next_tx_state;

    always_comb begin
        next_ctrl = ctrl;
        next_vlan_type = vlan_type;
        if (wr_pend && wr_addr == ADDR_CTRL) begin
            next_ctrl = hwdata_in & CTRL_WRITE_MASK;
        end
        if (wr_pend && wr_addr == ADDR_VLAN) begin
            next_vlan_type = hwdata_in[15:0];
        end
        rd_req = hsel_in && hready_in && htrans_in[1] && !hwrite_in;
        next_wr_pend = hsel_in && hready_in && htrans_in[1] && hwrite_in;
        next_wr_addr = haddr_in[7:0];
        next_hrdata = 32'h0000_0000;
        if (rd_req) begin
            case (haddr_in[7:0])
                ADDR_CTRL: next_hrdata = next_ctrl;
                ADDR_VLAN: next_hrdata = {16'h0000, next_vlan_type};
                ADDR_STATUS: begin
                    next_hrdata[STATUS_RX_BUSY_BIT] = rx_state != RX_PASS;
                    next_hrdata[STATUS_TX_BUSY_BIT] = tx_state != TX_IDLE;
                end
                ADDR_RX_SUM: next_hrdata = {16'h0000, rx_sum};
                ADDR_TX_SUM: next_hrdata = {16'h0000, tx_sum};
                default: next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl <= CTRL_RESET;
            vlan_type <= VLAN_RESET;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata_out <= 32'h0000_0000;
            hreadyout_out <= 1'b0;
            hresp_out <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            vlan_type <= next_vlan_type;
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata_out <= next_hrdata;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end
    end

    // ============================================================
    // Receive engine
    logic rx_en, rx_mode;
    logic rx_take, rx_first, next_rx_first, next_rx_ready, rx_sum_byte;
    logic [15:0] rx_acc;
    rx_stream_t next_rx_out;

    assign rx_en = ctrl[CTRL_RX_EN_BIT];
    assign rx_mode = ctrl[CTRL_RX_MODE_BIT];
    assign rx_take = rx_in.valid && rx_ready_out;

    rx_l3_locator u_locator (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .valid_in(rx_take),
        .first_in(rx_first),
        .data_in(rx_in.data),
        .mode_in(rx_mode),
        .vlan_type_in(vlan_type),
        .sum_byte_out(rx_sum_byte)
    );

    // The MAC delivers frame bytes without the FCS, so every byte from the start offset to last is summed.
    csum_accum u_rx_accum (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .clear_in(rx_take && rx_first),
        .add_in(rx_take && rx_en && rx_sum_byte),
        .data_in(rx_in.data),
        .sum_out(rx_acc)
    );

    always_comb begin
        next_rx_state = rx_state;
        next_rx_first = rx_first;
        next_rx_sum = rx_sum;
        next_rx_out = '0;
        case (rx_state)
            RX_PASS: begin
                if (rx_take) begin
                    next_rx_out.valid = 1'b1;
                    next_rx_out.data = rx_in.data;
                    next_rx_out.last = rx_in.last && !rx_en;
                    next_rx_first = rx_in.last;
                    if (rx_in.last && rx_en) begin
                        next_rx_state = RX_SUM_LO;
                    end
                end
            end
            RX_SUM_LO: begin
                next_rx_sum = rx_acc;
                next_rx_out.valid = 1'b1;
                next_rx_out.data = rx_acc[7:0];
                next_rx_state = RX_SUM_HI;
            end
            RX_SUM_HI: begin
                next_rx_out.valid = 1'b1;
                next_rx_out.data = rx_sum[15:8];
                next_rx_out.last = 1'b1;
                next_rx_out.csum_added = 1'b1;
                next_rx_state = RX_PASS;
            end
            default: next_rx_state = RX_PASS;
        endcase
        // Input is held off while the final frame byte and the low checksum byte go out.
        next_rx_ready = next_rx_state == RX_PASS;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rx_state <= RX_PASS;
            rx_first <= 1'b1;
            rx_sum <= ZERO_SUM;
            rx_out <= '0;
            rx_ready_out <= 1'b0;
        end else begin
            rx_state <= next_rx_state;
            rx_first <= next_rx_first;
            rx_sum <= next_rx_sum;
            rx_out <= next_rx_out;
            rx_ready_out <= next_rx_ready;
        end
    end

    // ============================================================
    // Transmit engine
    // The insert offset may lie before the end of the summed range, so the
    // packet is stored whole and replayed; bytes past TX_BUF_DEPTH are lost.
    logic [7:0] tx_buf [TX_BUF_DEPTH];
    logic do_pre, next_do_pre, do_csum, next_do_csum;
    logic [31:0] preamble, next_preamble;
    logic [1:0] pre_cnt, next_pre_cnt;
    logic [IW-1:0] wr_idx, next_wr_idx, rd_idx, next_rd_idx;
    logic tx_take, cmd_take, buf_we, next_tx_ready, next_cmd_ready;
    logic [15:0] tx_acc, ins_val;
    logic [IW-1:0] start_ofs, loc_ofs;
    byte_stream_t next_tx_out;

    assign tx_take = tx_in.valid && tx_ready_out;
    assign cmd_take = tx_cmd_in.valid && tx_cmd_ready_out;
    assign start_ofs = preamble[PRE_START_LSB +: IW];
    assign loc_ofs = preamble[PRE_LOC_LSB +: IW];

    csum_accum u_tx_accum (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .clear_in(cmd_take),
        .add_in(tx_take && tx_state == TX_LOAD && do_csum && wr_idx >= start_ofs),
        .data_in(tx_in.data),
        .sum_out(tx_acc)
    );

    always_comb begin
        ins_val = ~tx_acc;
        if (preamble[PRE_ZERO_SUB_BIT] && ins_val == ZERO_SUM) begin
            ins_val = ZERO_SUBSTITUTE;
        end
    end

    always_comb begin
        next_tx_state = tx_state;
        next_do_pre = do_pre;
        next_do_csum = do_csum;
        next_preamble = preamble;
        next_pre_cnt = pre_cnt;
        next_wr_idx = wr_idx;
        next_rd_idx = rd_idx;
        next_tx_sum = tx_sum;
        next_tx_out = '0;
        buf_we = 1'b0;
        case (tx_state)
            TX_IDLE: begin
                if (cmd_take) begin
                    next_do_pre = ctrl[CTRL_TX_EN_BIT] && tx_cmd_in.cmd_a[FIRST_SEG_BIT];
                    next_do_csum = next_do_pre && tx_cmd_in.cmd_b[CSUM_REQ_BIT];
                    next_wr_idx = '0;
                    next_pre_cnt = 2'h0;
                    next_tx_state = next_do_pre ? TX_PRE : TX_LOAD;
                end
            end
            TX_PRE: begin
                if (tx_take) begin
                    // The preamble is consumed here and never forwarded.
                    next_preamble = {tx_in.data, preamble[31:8]};
                    next_pre_cnt = pre_cnt + 2'h1;
                    if (tx_in.last) begin
                        next_tx_state = TX_IDLE;
                    end else if (pre_cnt == PRE_LAST_BYTE) begin
                        next_tx_state = TX_LOAD;
                    end
                end
            end
            TX_LOAD: begin
                if (tx_take) begin
                    buf_we = wr_idx < IW'(TX_BUF_DEPTH);
                    next_wr_idx = wr_idx + 12'h001;
                    if (tx_in.last) begin
                        next_rd_idx = '0;
                        next_tx_state = TX_SEND;
                    end
                end
            end
            TX_SEND: begin
                next_tx_out.valid = 1'b1;
                next_tx_out.data = tx_buf[rd_idx[AW-1:0]];
                if (do_csum && rd_idx == loc_ofs) begin
                    next_tx_out.data = ins_val[7:0];
                    next_tx_sum = ins_val;
                end
                if (do_csum && rd_idx == loc_ofs + 12'h001) begin
                    next_tx_out.data = ins_val[15:8];
                end
                next_tx_out.last = rd_idx == wr_idx - 12'h001;
                next_rd_idx = rd_idx + 12'h001;
                if (next_tx_out.last) begin
                    next_tx_state = TX_IDLE;
                end
            end
            default: next_tx_state = TX_IDLE;
        endcase
        next_cmd_ready = next_tx_state == TX_IDLE;
        next_tx_ready = next_tx_state == TX_PRE || next_tx_state == TX_LOAD;
    end

    always_ff @(posedge clk_in) begin
        if (buf_we) begin
            tx_buf[wr_idx[AW-1:0]] <= tx_in.data;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tx_state <= TX_IDLE;
            do_pre <= 1'b0;
            do_csum <= 1'b0;
            preamble <= 32'h0000_0000;
            pre_cnt <= 2'h0;
            wr_idx <= '0;
            rd_idx <= '0;
            tx_sum <= ZERO_SUM;
            tx_out <= '0;
            tx_ready_out <= 1'b0;
            tx_cmd_ready_out <= 1'b0;
        end else begin
            tx_state <= next_tx_state;
            do_pre <= next_do_pre;
            do_csum <= next_do_csum;
            preamble <= next_preamble;
            pre_cnt <= next_pre_cnt;
            wr_idx <= next_wr_idx;
            rd_idx <= next_rd_idx;
            tx_sum <= next_tx_sum;
            tx_out <= next_tx_out;
            tx_ready_out <= next_tx_ready;
            tx_cmd_ready_out <= next_cmd_ready;
        end
    end

endmodule

// [fco_props.sv]
// Port-level concurrent checks for the frame checksum offload block.
module fco_props
    import frame_checksum_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic hsel_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire byte_stream_t rx_in,
    input wire logic rx_ready_out,
    input wire rx_stream_t rx_out,
    input wire tx_cmd_t tx_cmd_in,
    input wire logic tx_cmd_ready_out,
    input wire byte_stream_t tx_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    logic rx_take;
    assign rx_take = rx_in.valid && rx_ready_out;
    // Two refused cycles carry the final frame byte and the low checksum byte.
    sequence s_append;
        (!rx_ready_out && rx_out.valid && !rx_out.last) [*2];
    endsequence
    sequence s_close;
        rx_ready_out && rx_out.valid && rx_out.last && rx_out.csum_added;
    endsequence
    property p_hresp;
        !hresp_out;
    endproperty
    a_hresp: assert property (p_hresp) else $error("hresp not okay");
    property p_ready;
        $past(nrst_in) |-> hreadyout_out;
    endproperty
    a_ready: assert property (p_ready) else $error("hreadyout low");
    property p_rdata_idle;
        !$past(hsel_in && htrans_in[1] && !hwrite_in) |-> hrdata_out == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("hrdata not cleared");
    property p_rx_echo;
        rx_take && !rx_in.last |=> rx_out.valid && !rx_out.last && rx_out.data == $past(rx_in.data);
    endproperty
    a_rx_echo: assert property (p_rx_echo) else $error("rx byte not echoed");
    property p_rx_last;
        rx_take && rx_in.last |=> rx_out.valid && rx_out.data == $past(rx_in.data) && rx_out.last == rx_ready_out;
    endproperty
    a_rx_last: assert property (p_rx_last) else $error("rx final byte wrong");
    property p_rx_append;
        $fell(rx_ready_out) |-> s_append ##1 s_close;
    endproperty
    a_rx_append: assert property (p_rx_append) else $error("rx append wrong");
    property p_csum_flag;
        rx_out.csum_added |-> rx_out.last && !$past(rx_ready_out);
    endproperty
    a_csum_flag: assert property (p_csum_flag) else $error("csum flag misplaced");
    property p_cmd_busy;
        tx_cmd_in.valid && tx_cmd_ready_out |=> !tx_cmd_ready_out;
    endproperty
    a_cmd_busy: assert property (p_cmd_busy) else $error("cmd ready stayed high");
    property p_tx_send;
        tx_out.valid && !tx_out.last |-> !tx_cmd_ready_out;
    endproperty
    a_tx_send: assert property (p_tx_send) else $error("cmd ready while sending");
endmodule

bind frame_checksum_offload fco_props props_u (.*);

// [fco_mac_model.sv]
// Behavioural MAC side: feeds receive bytes and collects both output streams.
module fco_mac_model
    import frame_checksum_pkg::*;
(
    input wire logic clk_in,
    input wire logic rx_ready_in,
    input wire rx_stream_t rx_out_in,
    input wire byte_stream_t tx_out_in,
    output byte_stream_t rx_in_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] src[$];
    logic [9:0] rxq[$];
    logic [8:0] txq[$];
    initial rx_in_out = '0;
    // A byte stands until ready is sampled high.
    always @(posedge clk_in) begin
        if (rx_in_out.valid && rx_ready_in) void'(src.pop_front());
        if (src.size() > 0) rx_in_out <= {1'b1, src[0]};
        else rx_in_out <= {2'b00, ~rx_in_out.data};
        if (rx_out_in.valid) rxq.push_back(rx_out_in[9:0]);
        if (tx_out_in.valid) txq.push_back(tx_out_in[8:0]);
    end
endmodule

// [frame_checksum_offload_test.sv]
// Self-checking bench for the frame checksum offload block.
module frame_checksum_offload_test
    import frame_checksum_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic hreadyout;
    byte_stream_t rx_in;
    logic rx_ready;
    rx_stream_t rx_out;
    tx_cmd_t tx_cmd = '0;
    logic tx_cmd_ready;
    byte_stream_t tx_in = '0;
    logic tx_ready;
    byte_stream_t tx_out;
    int num_errors = 0;
    int num_checks = 0;
    logic [7:0] f[$];
    frame_checksum_offload #(.TX_BUF_DEPTH(64)) dut_u (.clk_in(clk_in), .nrst_in(nrst_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(),
        .rx_in(rx_in), .rx_ready_out(rx_ready), .rx_out(rx_out), .tx_cmd_in(tx_cmd),
        .tx_cmd_ready_out(tx_cmd_ready), .tx_in(tx_in), .tx_ready_out(tx_ready), .tx_out(tx_out));
    fco_mac_model mac_u (.clk_in(clk_in), .rx_ready_in(rx_ready), .rx_out_in(rx_out), .tx_out_in(tx_out),
        .rx_in_out(rx_in));
    initial forever #12.5 clk_in = ~clk_in;
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        end_sim();
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, inout logic [31:0] d);
        @(posedge clk_in);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        do @(posedge clk_in); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0000_0000;
        do @(posedge clk_in); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d = '0;
        bus(1'b0, a, d);
        check("register", d, e);
    endtask
    function automatic void mk(input int n, input logic [7:0] b);
        for (int i = 0; i < n; i++) f.push_back(8'(b + i));
    endfunction
    // Reference sum: later byte is the high byte, carries fold back, an odd tail pads with zero.
    function automatic logic [15:0] csum(input int s);
        logic [16:0] a = '0;
        for (int i = s; i < f.size(); i += 2) a = a[15:0] + a[16] + {(i + 1 < f.size()) ? f[i + 1] : 8'h00, f[i]};
        return a[15:0] + a[16];
    endfunction
    task automatic rx_frame(input string name, input int s);
        logic [15:0] c = csum(s);
        int n = f.size();
        mac_u.rxq.delete();
        foreach (f[i]) mac_u.src.push_back({i == n - 1, f[i]});
        for (int k = 0; k < 300 && !(mac_u.rxq.size() && mac_u.rxq[$][9]); k++) @(posedge clk_in);
        check(name, mac_u.rxq.size(), n + (s > 0 ? 2 : 0));
        foreach (f[i]) check(name, mac_u.rxq[i], {s == 0 && i == n - 1, 1'b0, f[i]});
        if (s > 0) begin
            check(name, mac_u.rxq[n], {2'b00, c[7:0]});
            check(name, mac_u.rxq[n + 1], {2'b11, c[15:8]});
            rd(ADDR_RX_SUM, {16'h0000, c});
        end
        f.delete();
        $display("test %s done", name);
    endtask
    task automatic t_regs();
        rd(ADDR_CTRL, 32'h0000_0000);
        rd(ADDR_VLAN, 32'h0000_8100);
        wr(ADDR_CTRL, 32'hFFFF_FFFF);
        rd(ADDR_CTRL, 32'h0003_0003);
        wr(ADDR_STATUS, 32'hFFFF_FFFF);
        rd(ADDR_STATUS, 32'h0000_0000);
        rd(8'h20, 32'h0000_0000);
        wr(ADDR_CTRL, 32'h0000_0000);
        $display("test regs done");
    endtask
    task automatic t_rx();
        mk(12, 8'h10);
        f = {f, 8'h08, 8'h00, 8'h5A, 8'hA5, 8'h3C};
        rx_frame("rx off", 0);
        wr(ADDR_CTRL, 32'h0000_0001);
        mk(12, 8'h20);
        f = {f, 8'h81, 8'h00, 8'hFF, 8'hFF, 8'h01};
        rx_frame("rx mode0", 14);
        wr(ADDR_CTRL, 32'h0000_0003);
        mk(12, 8'h30);
        f = {f, 8'h81, 8'h00, 8'hAA, 8'hBB, 8'h81, 8'h00, 8'hCC, 8'hDD, 8'h81, 8'h00};
        mk(5, 8'hF0);
        rx_frame("rx tags", 22);
        mk(12, 8'h40);
        f = {f, 8'h00, 8'h20};
        mk(12, 8'h70);
        rx_frame("rx snap", 22);
        wr(ADDR_VLAN, 32'h0000_88A8);
        rd(ADDR_VLAN, 32'h0000_88A8);
        mk(12, 8'h50);
        f = {f, 8'h88, 8'hA8, 8'h11, 8'h22, 8'h08, 8'h00, 8'hE1, 8'hE2, 8'hE3};
        rx_frame("rx vlan", 18);
        wr(ADDR_CTRL, 32'h0000_0000);
    endtask
    task automatic tx_case(input string name, input bit en, input bit req, input logic [31:0] pre);
        logic [7:0] b[$] = f;
        logic [7:0] e[$] = f;
        logic [15:0] c = ~csum(pre[11:0]);
        int l = pre[27:16];
        wr(ADDR_CTRL, en ? 32'h0001_0000 : 32'h0000_0000);
        mac_u.txq.delete();
        if (pre[31] && c == 16'h0000) c = 16'hFFFF;
        if (en) b = {pre[7:0], pre[15:8], pre[23:16], pre[31:24], b};
        if (en && req) e[l] = c[7:0];
        if (en && req) e[l + 1] = c[15:8];
        @(posedge clk_in);
        tx_cmd <= {1'b1, 32'h0000_1000, req ? 32'h0000_2000 : 32'h0000_0000};
        do @(posedge clk_in); while (tx_cmd_ready !== 1'b1);
        tx_cmd <= ~tx_cmd;
        foreach (b[i]) begin
            tx_in <= {1'b1, i == b.size() - 1, b[i]};
            do @(posedge clk_in); while (tx_ready !== 1'b1);
        end
        tx_in <= {2'b00, ~tx_in.data};
        for (int k = 0; k < 300 && !(mac_u.txq.size() && mac_u.txq[$][8]); k++) @(posedge clk_in);
        check(name, mac_u.txq.size(), e.size());
        foreach (e[i]) check(name, mac_u.txq[i], {i == e.size() - 1, e[i]});
        if (en && req) rd(ADDR_TX_SUM, {16'h0000, c});
        $display("test %s done", name);
    endtask
    task automatic t_tx();
        mk(14, 8'h60);
        f = {f, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
        tx_case("tx zero", 1'b1, 1'b1, 32'h000E_000E);
        tx_case("tx subst", 1'b1, 1'b1, 32'h800E_000E);
        tx_case("tx no req", 1'b1, 1'b0, 32'h800E_000E);
        tx_case("tx off", 1'b0, 1'b1, 32'h800E_000E);
        f[18] = 8'h12;
        f[19] = 8'h34;
        tx_case("tx sum", 1'b1, 1'b1, 32'h800E_000E);
    endtask
    initial begin
        repeat (5) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        t_regs();
        t_rx();
        t_tx();
        end_sim();
    end
endmodule
